//--- motor_status_pkg.sv
/*
 * Constants shared by the motor position status output block: register map,
 * field positions, reset values and time constants.
 * Assumes a 25 MHz system clock and a 32-bit AHB-Lite register bus.
 */
`default_nettype none

package motor_status_pkg;

	// Byte offsets of the word registers.
	localparam logic [7:0] ctrl_off       = 8'h00;
	localparam logic [7:0] status_off     = 8'h04;
	localparam logic [7:0] rev_width_off  = 8'h08;
	localparam logic [7:0] steps_rev_off  = 8'h0C;
	localparam logic [7:0] wrap_width_off = 8'h10;
	localparam logic [7:0] wrap_range_off = 8'h14;
	localparam logic [7:0] wrap_div_off   = 8'h18;
	localparam logic [7:0] area_off_off   = 8'h1C;
	localparam logic [7:0] area_width_off = 8'h20;
	localparam logic [7:0] home_off       = 8'h24;

	// Control register fields.
	localparam int ctrl_wrap_en_bit  = 0;
	localparam int ctrl_wrap_src_bit = 1;
	localparam int ctrl_area_src_lsb = 2;
	localparam int ctrl_preset_bit   = 4;

	// Status register fields.
	localparam int st_feedback_bit = 0;
	localparam int st_monitor_bit  = 1;
	localparam int st_excite_bit   = 2;
	localparam int st_rev_bit      = 3;
	localparam int st_wrap_bit     = 4;
	localparam int st_tick_bit     = 5;
	localparam int st_area_bit     = 6;

	// Values after reset, and the largest values a write is clamped to.
	localparam logic [10:0] rev_width_rst  = 11'h012;
	localparam logic [31:0] steps_rev_rst  = 32'h0000_03E8;
	localparam logic [13:0] wrap_width_rst = 14'h000A;
	localparam logic [31:0] wrap_range_rst = 32'h0000_03E8;
	localparam logic [28:0] wrap_div_rst   = 29'h0000_0001;
	localparam logic [31:0] area_width_rst = 32'hFFFF_FFFF;
	localparam logic [10:0] rev_width_max  = 11'h708;
	localparam logic [13:0] wrap_width_max = 14'h2710;
	localparam logic [28:0] wrap_div_max   = 29'h1FFF_FFFF;

	// Angle tick spacing: 7.2 degrees = 72 tenths of a degree out of 3600.
	localparam logic [31:0] tick_tenths = 32'h0000_0048;
	localparam logic [31:0] rev_tenths  = 32'h0000_0E10;

	// Tick output pulse time and its cycle count at the clock rate.
	localparam int clk_hz         = 25_000_000;
	localparam int tick_pulse_us  = 500;
	localparam int tick_pulse_cyc = (tick_pulse_us * (clk_hz / 1_000_000) < 1) ? 1 :
		tick_pulse_us * (clk_hz / 1_000_000);

	typedef enum logic [2:0]
	{
		area_idle_s = 3'b001,
		area_run_s  = 3'b010,
		area_done_s = 3'b100
	} area_state_t;

endpackage : motor_status_pkg

`default_nettype wire

//--- motor_position_status_outputs.sv
/*
 * Position and safety status outputs of a stepping motor driver, with an
 * AHB-Lite slave for configuration and status.
 * Assumes positions and operation events arrive synchronous to clk_i from the
 * position computation logic, and a single AHB-Lite master.
 */
// The placing of the registers and register access over AHB-Lite were left to the implementer.
// Functional notes
// [RULE1] Safety feedback on only when both torque-off inputs are off.
// [RULE2] Motor excited only while both torque-off inputs are on.
// [RULE3] Monitor on whenever at least one torque-off input is off.
// [RULE4] Revolution output on each full feedback revolution from preset origin.
// [RULE5] Revolution output width 1 to 1800 tenths of a degree, default 18.
// [RULE6] Host should pick revolution width giving at least 1 ms on.
// [RULE7] With wrap enabled, wrap-zero output on at wrap home position.
// [RULE8] Wrap-zero width 1 to 10000 steps, default 10.
// [RULE9] Wrap-zero source: 0 feedback, 1 command position, default 0.
// [RULE10] Wrap range split into 1 to 536870911 zones, marker at each.
// [RULE11] Angle tick output each 7.2 degrees of command position from home.
// [RULE12] Angle tick correct only below 1000 Hz command speed.
// [RULE13] Motion-area output on while position inside operation area.
// [RULE14] Area source selects position and hold-on or clear-at-completion.
// [RULE15] Area width per operation, default -1.
// [RULE16] Area centred at target plus offset, within plus or minus width.
// [RULE17] Continuous operation types reference offset to start position.
`timescale 1ns/10ps
`default_nettype none

module motor_position_status_outputs
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        torque_off_input_a_i,
	input  wire logic        torque_off_input_b_i,
	input  wire logic [31:0] feedback_pos_i,
	input  wire logic [31:0] command_pos_i,
	input  wire logic        op_start_i,
	input  wire logic        op_done_i,
	input  wire logic        op_continuous_i,
	input  wire logic [31:0] op_target_pos_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	output logic             safety_feedback_out_o,
	output logic             torque_off_input_monitor_o,
	output logic             motor_excite_o,
	output logic             once_per_rev_out_o,
	output logic             wrap_zero_out_o,
	output logic             angle_tick_out_o,
	output logic             motion_area_out_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave.

	logic        wr_pend_q;
	logic [7:0]  wr_addr_q;
	logic [31:0] ctrl_q;
	logic [10:0] rev_width_q;
	logic [31:0] steps_rev_q;
	logic [13:0] wrap_width_q;
	logic [31:0] wrap_range_q;
	logic [28:0] wrap_div_q;
	logic [31:0] area_offset_q;
	logic [31:0] area_width_q;
	logic [31:0] home_q;
	logic [31:0] rev_origin_q;
	logic [31:0] hrdata_q;
	logic [6:0]  status_w;

	wire bus_go   = hsel_i & htrans_i[1] & hready_i;
	wire wr_go    = bus_go & hwrite_i;
	wire rd_go    = bus_go & ~hwrite_i;
	wire [7:0] ra = haddr_i[7:0];
	// Write strobes: address taken in the address phase, data in the data phase.
	wire wr_ctrl       = wr_pend_q & (wr_addr_q == motor_status_pkg::ctrl_off);
	wire wr_rev_width  = wr_pend_q & (wr_addr_q == motor_status_pkg::rev_width_off);
	wire wr_steps_rev  = wr_pend_q & (wr_addr_q == motor_status_pkg::steps_rev_off);
	wire wr_wrap_width = wr_pend_q & (wr_addr_q == motor_status_pkg::wrap_width_off);
	wire wr_wrap_range = wr_pend_q & (wr_addr_q == motor_status_pkg::wrap_range_off);
	wire wr_wrap_div   = wr_pend_q & (wr_addr_q == motor_status_pkg::wrap_div_off);
	wire wr_area_off   = wr_pend_q & (wr_addr_q == motor_status_pkg::area_off_off);
	wire wr_area_width = wr_pend_q & (wr_addr_q == motor_status_pkg::area_width_off);
	wire wr_home       = wr_pend_q & (wr_addr_q == motor_status_pkg::home_off);

	wire preset_w = wr_ctrl & hwdata_i[motor_status_pkg::ctrl_preset_bit]; // RULE4

	// Out-of-range values are clamped on the whole word, so a large write cannot
	// wrap round into a small width or zone count.
	wire rev_over  = (hwdata_i > {21'h0, motor_status_pkg::rev_width_max});
	wire wrap_over = (hwdata_i > {18'h0, motor_status_pkg::wrap_width_max});
	wire div_over  = (hwdata_i > {3'h0, motor_status_pkg::wrap_div_max});
	wire [10:0] rev_wdat = (hwdata_i == 32'h0000_0000) ? 11'h001 :
		rev_over ? motor_status_pkg::rev_width_max : hwdata_i[10:0]; // RULE5
	wire [13:0] wrap_wdat = (hwdata_i == 32'h0000_0000) ? 14'h0001 :
		wrap_over ? motor_status_pkg::wrap_width_max : hwdata_i[13:0]; // RULE8
	wire [28:0] div_wdat = (hwdata_i == 32'h0000_0000) ? 29'h0000_0001 :
		div_over ? motor_status_pkg::wrap_div_max : hwdata_i[28:0]; // RULE10

	// Unmapped offsets read as zero.
	wire [31:0] rd_mux =
		(ra == motor_status_pkg::ctrl_off)       ? {27'h0, ctrl_q[4:0] & 5'h0F} :
		(ra == motor_status_pkg::status_off)     ? {25'h0, status_w} :
		(ra == motor_status_pkg::rev_width_off)  ? {21'h0, rev_width_q} :
		(ra == motor_status_pkg::steps_rev_off)  ? steps_rev_q :
		(ra == motor_status_pkg::wrap_width_off) ? {18'h0, wrap_width_q} :
		(ra == motor_status_pkg::wrap_range_off) ? wrap_range_q :
		(ra == motor_status_pkg::wrap_div_off)   ? {3'h0, wrap_div_q} :
		(ra == motor_status_pkg::area_off_off)   ? area_offset_q :
		(ra == motor_status_pkg::area_width_off) ? area_width_q :
		(ra == motor_status_pkg::home_off)       ? home_q : 32'h0000_0000;

	// hreadyout is tied high: every transfer has one data phase and no wait state.
	// The write address is held over into the data phase, where hwdata_i is valid.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata_q  <= 32'h0000_0000;
		end
		else
		begin
			wr_pend_q <= wr_go;
			if (wr_go)
				wr_addr_q <= ra;
			if (rd_go)
				hrdata_q <= rd_mux;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ctrl_q        <= 32'h0000_0000;
			rev_width_q   <= motor_status_pkg::rev_width_rst;
			steps_rev_q   <= motor_status_pkg::steps_rev_rst;
			wrap_width_q  <= motor_status_pkg::wrap_width_rst;
			wrap_range_q  <= motor_status_pkg::wrap_range_rst;
			wrap_div_q    <= motor_status_pkg::wrap_div_rst;
			area_offset_q <= 32'h0000_0000;
			area_width_q  <= motor_status_pkg::area_width_rst; // RULE15
			home_q        <= 32'h0000_0000;
		end
		else
		begin
			// Control bit 4 is a strobe and is never stored, so it always reads back 0.
			if (wr_ctrl)
				ctrl_q <= {28'h0, hwdata_i[3:0]};
			if (wr_rev_width)
				rev_width_q <= rev_wdat; // RULE5
			if (wr_steps_rev)
				steps_rev_q <= hwdata_i;
			if (wr_wrap_width)
				wrap_width_q <= wrap_wdat; // RULE8
			if (wr_wrap_range)
				wrap_range_q <= hwdata_i;
			if (wr_wrap_div)
				wrap_div_q <= div_wdat; // RULE10
			if (wr_area_off)
				area_offset_q <= hwdata_i; // RULE16
			if (wr_area_width)
				area_width_q <= hwdata_i; // RULE15
			if (wr_home)
				home_q <= hwdata_i; // RULE11
		end
	end

	assign hrdata_o    = hrdata_q;
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// Safety feedback.

	wire both_off = ~torque_off_input_a_i & ~torque_off_input_b_i;
	wire both_on  = torque_off_input_a_i & torque_off_input_b_i;
	wire either_off = ~both_on;
	// The three safety outputs are registered from one sample, so they agree in every cycle out of reset.
	logic feedback_q;
	logic monitor_q;
	logic excite_q;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			feedback_q <= 1'b0;
			monitor_q  <= 1'b0;
			excite_q   <= 1'b0;
		end
		else
		begin
			feedback_q <= both_off; // RULE1
			monitor_q  <= either_off; // RULE3
			excite_q   <= both_on; // RULE2
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Once-per-revolution output. Width in steps is width_tenths*steps/3600 plus one.

	wire [31:0] rev_rel   = feedback_pos_i - rev_origin_q;
	// A zero step count would divide by zero; it is taken as one step per revolution.
	wire [31:0] rev_phase = rev_rel % ((steps_rev_q == 32'h0) ? 32'h1 : steps_rev_q);
	wire [42:0] rev_prod  = {11'h0, steps_rev_q} * {32'h0, rev_width_q};
	wire [42:0] rev_wid   = rev_prod / {11'h0, motor_status_pkg::rev_tenths};
	wire        rev_on    = ({11'h0, rev_phase} <= rev_wid); // RULE4 RULE5
	logic       rev_q;

	// Wrap-zero: phase within one zone of the wrap range.
	wire [31:0] wrap_pos  = ctrl_q[motor_status_pkg::ctrl_wrap_src_bit] ?
		command_pos_i : feedback_pos_i; // RULE9
	wire [31:0] wrap_rng  = (wrap_range_q == 32'h0) ? 32'h1 : wrap_range_q;
	wire [31:0] zone_len  = wrap_rng / {3'h0, wrap_div_q}; // RULE10
	wire [31:0] zone_safe = (zone_len == 32'h0) ? 32'h1 : zone_len;
	wire [31:0] zone_ph   = (wrap_pos % wrap_rng) % zone_safe;
	// The marker straddles each zone start: half before, half after.
	// An odd width puts its extra step after the zone start.
	wire [31:0] half_w    = {19'h0, wrap_width_q[13:1]};
	wire        wrap_on   = ctrl_q[motor_status_pkg::ctrl_wrap_en_bit] &
		((zone_ph < half_w + {31'h0, wrap_width_q[0]}) |
		(zone_ph >= zone_safe - half_w)); // RULE7 RULE8
	logic       wrap_q;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rev_origin_q <= 32'h0000_0000;
			rev_q        <= 1'b0;
			wrap_q       <= 1'b0;
		end
		else
		begin
			if (preset_w)
				rev_origin_q <= feedback_pos_i; // RULE4
			rev_q  <= rev_on;
			wrap_q <= wrap_on;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Angle tick: fires on each crossing of a 7.2 degree boundary upward.
	// Crossings are detected as an index step of exactly one, so a speed above the rated command
	// rate may drop or merge ticks; that is accepted.

	wire [31:0] tick_steps = (steps_rev_q * motor_status_pkg::tick_tenths) /
		motor_status_pkg::rev_tenths;
	wire [31:0] tick_div   = (tick_steps == 32'h0) ? 32'h1 : tick_steps;
	wire [31:0] tick_rel   = command_pos_i - home_q;
	wire [31:0] tick_idx   = tick_rel / tick_div;
	logic [31:0] tick_idx_q;
	logic [14:0] tick_cnt_q;
	wire         tick_hit = (tick_idx == tick_idx_q + 32'h1); // RULE11 RULE12
	// The pulse is stretched to a fixed time so a slowly polling host sees every tick.
	wire         tick_busy = (tick_cnt_q != 15'h0000);

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tick_idx_q <= 32'h0000_0000;
			tick_cnt_q <= 15'h0000;
		end
		else
		begin
			tick_idx_q <= tick_idx;
			if (tick_hit)
				tick_cnt_q <= 15'(motor_status_pkg::tick_pulse_cyc);
			else if (tick_busy)
				tick_cnt_q <= tick_cnt_q - 15'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Motion area.

	motor_status_pkg::area_state_t area_state_q;
	logic [31:0] area_ref_q;
	logic        area_q;

	wire [1:0]  area_src   = ctrl_q[motor_status_pkg::ctrl_area_src_lsb +: 2];
	wire [31:0] area_pos   = area_src[0] ? command_pos_i : feedback_pos_i; // RULE14
	// The reference is latched at start, so a later target change leaves the area alone.
	wire [31:0] ref_sel    = op_continuous_i ? feedback_pos_i : op_target_pos_i; // RULE17
	wire [31:0] area_ctr   = area_ref_q + area_offset_q; // RULE16
	wire [31:0] area_diff  = area_pos - area_ctr;
	wire [31:0] area_abs   = area_diff[31] ? (32'h0 - area_diff) : area_diff;
	// A negative width leaves the area disabled.
	wire        area_in    = ~area_width_q[31] & (area_abs <= area_width_q); // RULE13 RULE16
	// The output stays low before the first operation: no area has been defined yet.
	wire        area_clr   = area_src[1] & (area_state_q == motor_status_pkg::area_done_s);

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			area_state_q <= motor_status_pkg::area_idle_s;
			area_ref_q   <= 32'h0000_0000;
			area_q       <= 1'b0;
		end
		else
		begin
			unique case (area_state_q)
				motor_status_pkg::area_idle_s,
				motor_status_pkg::area_done_s:
					if (op_start_i)
					begin
						area_ref_q   <= ref_sel; // RULE17
						area_state_q <= motor_status_pkg::area_run_s;
					end
				motor_status_pkg::area_run_s:
					if (op_done_i)
						area_state_q <= motor_status_pkg::area_done_s;
				default:
					area_state_q <= motor_status_pkg::area_idle_s;
			endcase
			area_q <= area_in & ~area_clr & (area_state_q != motor_status_pkg::area_idle_s); // RULE14
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs and status.

	assign safety_feedback_out_o      = feedback_q;
	assign torque_off_input_monitor_o = monitor_q;
	assign motor_excite_o             = excite_q;
	assign once_per_rev_out_o         = rev_q;
	assign wrap_zero_out_o            = wrap_q;
	assign angle_tick_out_o           = tick_busy;
	assign motion_area_out_o          = area_q;
	// Status mirrors the registered outputs, so a read shows what the pins showed.
	assign status_w = {area_q, angle_tick_out_o, wrap_q, rev_q, excite_q, monitor_q, feedback_q};

endmodule : motor_position_status_outputs

`default_nettype wire

//--- motor_status_sva.sv
/* Checker for the torque-off and tick outputs of the status block.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module motor_status_sva
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic torque_off_input_a_i,
	input wire logic torque_off_input_b_i,
	input wire logic safety_feedback_out_o,
	input wire logic torque_off_input_monitor_o,
	input wire logic motor_excite_o,
	input wire logic angle_tick_out_o
);
	logic live_q;
	// Attempts start one edge after reset release, once the outputs have left reset.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			live_q <= 1'b0;
		else
			live_q <= 1'b1;
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i || !live_q);
	wire logic both_off = !torque_off_input_a_i && !torque_off_input_b_i;
	wire logic both_on  = torque_off_input_a_i && torque_off_input_b_i;
	chk_feedback_on: assert property (both_off |=> safety_feedback_out_o)
		else $error("safety feedback not raised");
	chk_feedback_off: assert property (!both_off |=> !safety_feedback_out_o)
		else $error("safety feedback raised wrongly");
	chk_excite_on: assert property (both_on |=> motor_excite_o)
		else $error("motor not excited");
	chk_excite_off: assert property (!both_on |=> !motor_excite_o)
		else $error("motor excited wrongly");
	chk_monitor_on: assert property (!both_on |=> torque_off_input_monitor_o)
		else $error("monitor not raised");
	chk_monitor_off: assert property (both_on |=> !torque_off_input_monitor_o)
		else $error("monitor raised wrongly");
	chk_feedback_excl: assert property (safety_feedback_out_o |-> torque_off_input_monitor_o && !motor_excite_o)
		else $error("feedback disagrees with monitor");
	chk_tick_width: assert property ($rose(angle_tick_out_o) |-> angle_tick_out_o[*8])
		else $error("tick pulse too short");
	cover property (both_off ##1 safety_feedback_out_o);
	cover property ($rose(angle_tick_out_o));
	cover property ($fell(motor_excite_o));
endmodule : motor_status_sva
`default_nettype wire

//--- host_monitor.sv
/* Host side model: counts rising edges of the revolution and tick outputs.
   Assumes outputs are levels synchronous to clk_i. */
`timescale 1ns/10ps
`default_nettype none
module host_monitor
(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       once_per_rev_out_i,
	input  wire logic       angle_tick_out_i,
	output logic      [7:0] rev_count_o,
	output logic      [7:0] tick_count_o
);
	logic rev_q;
	logic tick_q;
	// The host samples once per clock, so the revolution width is chosen long enough to be seen.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rev_q <= 1'h0;
			tick_q <= 1'h0;
			rev_count_o <= 8'h00;
			tick_count_o <= 8'h00;
		end
		else
		begin
			rev_q <= once_per_rev_out_i;
			tick_q <= angle_tick_out_i;
			rev_count_o <= rev_count_o + {7'h00, once_per_rev_out_i & ~rev_q};
			tick_count_o <= tick_count_o + {7'h00, angle_tick_out_i & ~tick_q};
		end
	end
endmodule : host_monitor
`default_nettype wire

//--- motor_position_status_outputs_tb.sv
/* Self-checking bench for the status block, driving its AHB-Lite slave.
   Assumes a single slave whose hreadyout is the bus hready. */
`timescale 1ns/10ps
`default_nettype none
module motor_position_status_outputs_tb;
	logic clk_i = 1'h0, rst_n_i = 1'h0, to_a = 1'h1, to_b = 1'h1;
	logic [31:0] fb = '0, cmd = '0, tgt = '0, haddr = '0, hwdata = '0, rd;
	logic ost = 1'h0, odn = 1'h0, ocn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hrdata;
	logic hready, hresp, sfo, mon, exc, rev, wz, tik, area;
	logic [7:0] rev_cnt, tick_cnt, c0;
	int errors = 0, compares = 0, cycles = 0;
	logic [31:0] rev_pos [5] = '{32'h64, 32'h6A, 32'h44C, 32'h451, 32'h452};
	logic rev_exp [5] = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h0};
	always #20 clk_i = ~clk_i;
	motor_position_status_outputs motor_position_status_outputs_i (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .torque_off_input_a_i(to_a), .torque_off_input_b_i(to_b),
		.feedback_pos_i(fb), .command_pos_i(cmd), .op_start_i(ost), .op_done_i(odn),
		.op_continuous_i(ocn), .op_target_pos_i(tgt), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.safety_feedback_out_o(sfo), .torque_off_input_monitor_o(mon),
		.motor_excite_o(exc), .once_per_rev_out_o(rev), .wrap_zero_out_o(wz),
		.angle_tick_out_o(tik), .motion_area_out_o(area));
	host_monitor host_monitor_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .once_per_rev_out_i(rev),
		.angle_tick_out_i(tik), .rev_count_o(rev_cnt), .tick_count_o(tick_cnt));
	////////////////////////////////////////////////////////////////////////////////
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask : cyc
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		do @(posedge clk_i); while (hready !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_i); while (hready !== 1'h1);
		rd = hrdata;
		check("response", {31'h0, hresp}, 32'h0);
	endtask : bus
	task rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(1'h0, a, 32'h0);
		check(what, rd, exp);
	endtask : rdchk
	task setp(input logic [31:0] f, input logic [31:0] c);
		fb <= f;
		cmd <= c;
		cyc(3);
	endtask : setp
	task pulse_start();
		ost <= 1'h1;
		cyc(1);
		ost <= 1'h0;
		cyc(2);
	endtask : pulse_start
	task summarize();
		$display("Comparisons %0d, mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			errors++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		cyc(10);
		rst_n_i <= 1'h1;
		cyc(1);
		for (int i = 0; i < 4; i++)
		begin
			to_a <= i[1];
			to_b <= i[0];
			cyc(3);
			check("feedback", sfo, i == 0);
			check("monitor", mon, i != 3);
			check("excite", exc, i == 3);
			bus(1'h0, motor_status_pkg::status_off, 32'h0);
			check("status", rd[2:0], {i == 3, i != 3, i == 0});
		end
		$display("Test torque finished");
		rdchk("rev width", motor_status_pkg::rev_width_off, 32'h12);
		rdchk("wrap width", motor_status_pkg::wrap_width_off, 32'hA);
		rdchk("zones", motor_status_pkg::wrap_div_off, 32'h1);
		rdchk("area width", motor_status_pkg::area_width_off, 32'hFFFFFFFF);
		rdchk("unmapped", 8'h40, 32'h0);
		bus(1'h1, motor_status_pkg::rev_width_off, 32'h0);
		rdchk("rev width low", motor_status_pkg::rev_width_off, 32'h1);
		bus(1'h1, motor_status_pkg::rev_width_off, 32'h7D0);
		rdchk("rev width high", motor_status_pkg::rev_width_off, 32'h708);
		bus(1'h1, motor_status_pkg::rev_width_off, 32'h800);
		rdchk("rev width wide", motor_status_pkg::rev_width_off, 32'h708);
		bus(1'h1, motor_status_pkg::wrap_width_off, 32'h4E20);
		rdchk("wrap width high", motor_status_pkg::wrap_width_off, 32'h2710);
		bus(1'h1, motor_status_pkg::wrap_div_off, 32'h0);
		rdchk("zones low", motor_status_pkg::wrap_div_off, 32'h1);
		bus(1'h1, motor_status_pkg::wrap_div_off, 32'hFFFF_FFFF);
		rdchk("zones high", motor_status_pkg::wrap_div_off, 32'h1FFF_FFFF);
		bus(1'h1, motor_status_pkg::wrap_div_off, 32'h1);
		bus(1'h1, motor_status_pkg::wrap_width_off, 32'hA);
		bus(1'h1, motor_status_pkg::rev_width_off, 32'h12);
		$display("Test registers finished");
		setp(32'h64, 32'h0);
		bus(1'h1, motor_status_pkg::ctrl_off, 32'h10);
		c0 = rev_cnt;
		for (int i = 0; i < 5; i++)
		begin
			setp(rev_pos[i], 32'h0);
			check("revolution", rev, rev_exp[i]);
		end
		check("revolution count", rev_cnt, c0 + 8'h2);
		$display("Test revolution finished");
		bus(1'h1, motor_status_pkg::ctrl_off, 32'h1);
		setp(32'h0, 32'h0);
		check("wrap home", wz, 1'h1);
		setp(32'h1F4, 32'h0);
		check("wrap mid", wz, 1'h0);
		bus(1'h1, motor_status_pkg::wrap_div_off, 32'h2);
		cyc(3);
		check("wrap zone", wz, 1'h1);
		setp(32'hFA, 32'h0);
		check("wrap quarter", wz, 1'h0);
		bus(1'h1, motor_status_pkg::ctrl_off, 32'h3);
		cyc(3);
		check("wrap command", wz, 1'h1);
		bus(1'h1, motor_status_pkg::ctrl_off, 32'h0);
		cyc(3);
		check("wrap disabled", wz, 1'h0);
		$display("Test wrap finished");
		c0 = tick_cnt;
		// A jump of 19 steps then one step crosses one boundary, at a command rate far above the tick limit.
		setp(32'h0, 32'h13);
		check("tick early", tik, 1'h0);
		setp(32'h0, 32'h14);
		check("tick", tik, 1'h1);
		check("tick count", tick_cnt, c0 + 8'h1);
		$display("Test tick finished");
		bus(1'h1, motor_status_pkg::area_width_off, 32'hA);
		tgt <= 32'h1388;
		for (int m = 0; m < 4; m++)
		begin
			bus(1'h1, motor_status_pkg::ctrl_off, m << 2);
			pulse_start();
			setp(m[0] ? 32'h0 : 32'h138B, m[0] ? 32'h138B : 32'h0);
			check("area inside", area, 1'h1);
			setp(m[0] ? 32'h0 : 32'h1393, m[0] ? 32'h1393 : 32'h0);
			check("area outside", area, 1'h0);
			setp(m[0] ? 32'h0 : 32'h138B, m[0] ? 32'h138B : 32'h0);
			odn <= 1'h1;
			cyc(1);
			odn <= 1'h0;
			cyc(3);
			check("area after", area, m < 2);
		end
		bus(1'h1, motor_status_pkg::ctrl_off, 32'h0);
		bus(1'h1, motor_status_pkg::area_off_off, 32'h32);
		setp(32'h3E8, 32'h0);
		ocn <= 1'h1;
		tgt <= 32'h0;
		pulse_start();
		setp(32'h41A, 32'h0);
		check("area start ref", area, 1'h1);
		bus(1'h0, motor_status_pkg::status_off, 32'h0);
		check("status area", rd[6], 1'h1);
		setp(32'h32, 32'h0);
		check("area not target", area, 1'h0);
		$display("Test area finished");
		summarize();
	end
endmodule : motor_position_status_outputs_tb
bind motor_position_status_outputs motor_status_sva motor_status_sva_i (.clk_i(clk_i),
	.rst_n_i(rst_n_i), .torque_off_input_a_i(torque_off_input_a_i),
	.torque_off_input_b_i(torque_off_input_b_i), .safety_feedback_out_o(safety_feedback_out_o),
	.torque_off_input_monitor_o(torque_off_input_monitor_o), .motor_excite_o(motor_excite_o),
	.angle_tick_out_o(angle_tick_out_o));
`default_nettype wire
